//--- design/ptc_cfg.svh
`ifndef PTC_CFG_SVH
`define PTC_CFG_SVH
// Operation
// - client gives valid checksum offset when correcting
// - offset marks the two checksum bytes
// - offset used only in one-step mode
// - checksum must lie inside the packet
// - checksum clear of timestamp and other fields
// - asymmetry update adds programmed delay value
// - asymmetry update held during start-of-packet
// - two-step request marks packet as two-step
// - two-step reports timestamp, leaves packet unchanged
// - two-step request exactly aligned with SOP
// - two-step never with insert or residence
// - device outputs wide timestamp at start
// - wide valid pulses with timestamp and tag
// - device outputs narrow timestamp at start
// - narrow valid pulses with timestamp and tag
// - wide outputs exist only for wide formats
// - narrow outputs exist only for narrow formats
// - client fingerprint aligned with SOP
// - fingerprint width build parameter 1 to 32

// ----------------------------------------
// Stream and timestamp widths
// ----------------------------------------
`define PTC_DATA_W      64
`define PTC_BYTES       8
`define PTC_LANE_W      3
`define PTC_OFS_W       16
`define PTC_BEAT_W      13
`define PTC_WIDE_W      96
`define PTC_NARROW_W    64
`define PTC_ASYM_W      32
`define PTC_CSUM_W      16
`define PTC_TAG_W       8

// ----------------------------------------
// Time-of-day format selection
// ----------------------------------------
`define PTC_FMT_WIDE    2'h1
`define PTC_FMT_NARROW  2'h2
`define PTC_FMT_BOTH    2'h3

// ----------------------------------------
// Client register map (APB byte offsets)
// ----------------------------------------
`define PTC_REG_CTRL    8'h00
`define PTC_REG_OFS     8'h04
`define PTC_REG_LEN     8'h08
`define PTC_REG_TAG     8'h0c
`define PTC_REG_STAT    8'h10
`define PTC_REG_RTAG    8'h14
`define PTC_REG_TSLO    8'h18
`define PTC_REG_TSHI    8'h1c

`define PTC_CTRL_START  0
`define PTC_CTRL_CSUM   1
`define PTC_CTRL_ASYM   2
`define PTC_CTRL_TWO    3
`define PTC_CTRL_INS    4
`define PTC_CTRL_RT     5
`define PTC_CTRL_W      6

`define PTC_STAT_BUSY   0
`define PTC_STAT_WIDE   1
`define PTC_STAT_NARROW 2
`define PTC_LEN_W       8
`endif

//--- design/ptc_pkg.sv
`include "ptc_cfg.svh"
package ptc_pkg;
    typedef logic [`PTC_TAG_W-1:0]  ptc_tag_t;
    typedef logic [`PTC_DATA_W-1:0] ptc_data_t;

    typedef enum logic [0:0] {
        PTC_IDLE = 1'b0,
        PTC_SEND = 1'b1
    } ptc_cli_st_t;

    typedef struct packed {
        logic                     s_valid;
        logic                     s_sop;
        logic                     s_eop;
        ptc_data_t                s_data;
        logic                     s_two;
        ptc_tag_t                 s_tag;
        logic [`PTC_BEAT_W-1:0]   beat;
        logic                     fix_en;
        logic [`PTC_BEAT_W-1:0]   fix_beat;
        logic [`PTC_LANE_W-1:0]   fix_lane;
        logic                     asym_en;
        logic [`PTC_ASYM_W-1:0]   corr_adj;
        logic                     wide_ok;
        logic [`PTC_WIDE_W-1:0]   wide_ts;
        ptc_tag_t                 wide_tag;
        logic                     narrow_ok;
        logic [`PTC_NARROW_W-1:0] narrow_ts;
        ptc_tag_t                 narrow_tag;
    } ptc_dev_t;

    typedef struct packed {
        ptc_cli_st_t              st;
        logic [`PTC_CTRL_W-1:0]   ctrl;
        logic [`PTC_OFS_W-1:0]    ofs;
        logic [`PTC_LEN_W-1:0]    len;
        ptc_tag_t                 tag;
        logic [`PTC_LEN_W-1:0]    cnt;
        logic                     got_wide;
        logic                     got_narrow;
        ptc_tag_t                 rtag;
        logic [`PTC_NARROW_W-1:0] ts;
        logic                     pready;
        logic [31:0]              prdata;
        logic                     valid;
        logic                     sop;
        logic                     eop;
        ptc_data_t                data;
        logic                     csum_req;
        logic [`PTC_OFS_W-1:0]    csum_ofs;
        logic                     asym_upd;
        logic                     two_req;
        ptc_tag_t                 req_tag;
        logic                     ts_ins;
        logic                     rt_upd;
    } ptc_cli_t;
endpackage

//--- design/ptc_link_if.sv
`timescale 1ns/1ps
`include "ptc_cfg.svh"
interface ptc_link_if;
    import ptc_pkg::*;
    // ----------------------------------------
    // Client to device stream and controls
    // ----------------------------------------
    logic                     tx_valid;
    logic                     tx_sop;
    logic                     tx_eop;
    ptc_data_t                tx_data;
    logic                     checksum_correct;
    logic [`PTC_OFS_W-1:0]    checksum_fix_offset;
    logic                     asymmetry_update;
    logic                     two_step_request;
    ptc_tag_t                 request_tag_in;
    logic                     ts_insert;
    logic                     residence_update;
    // ----------------------------------------
    // Device to client egress results
    // ----------------------------------------
    logic [`PTC_WIDE_W-1:0]   egress_ts_wide;
    logic                     egress_ts_wide_ok;
    ptc_tag_t                 egress_tag_wide;
    logic [`PTC_NARROW_W-1:0] egress_ts_narrow;
    logic                     egress_ts_narrow_ok;
    ptc_tag_t                 egress_tag_narrow;

    modport dev (
        input  tx_valid, tx_sop, tx_eop, tx_data, checksum_correct, checksum_fix_offset,
        input  asymmetry_update, two_step_request, request_tag_in, ts_insert,
        input  residence_update,
        output egress_ts_wide, egress_ts_wide_ok, egress_tag_wide,
        output egress_ts_narrow, egress_ts_narrow_ok, egress_tag_narrow
    );
    modport cli (
        output tx_valid, tx_sop, tx_eop, tx_data, checksum_correct, checksum_fix_offset,
        output asymmetry_update, two_step_request, request_tag_in, ts_insert,
        output residence_update,
        input  egress_ts_wide, egress_ts_wide_ok, egress_tag_wide,
        input  egress_ts_narrow, egress_ts_narrow_ok, egress_tag_narrow
    );
endinterface

//--- design/ptc_dev.sv
`timescale 1ns/1ps
`include "ptc_cfg.svh"
module ptc_dev #(
    parameter logic [1:0] TOD_FMT = `PTC_FMT_BOTH
) (
    // Clock and reset
    input  wire logic                      pclk,
    input  wire logic                      presetn,
    // Client side
    ptc_link_if.dev                        lnk,
    // Mode and configuration
    input  wire logic                      one_step_mode,
    input  wire logic [`PTC_ASYM_W-1:0]    asymmetry_delay_value,
    // Time of day
    input  wire logic [`PTC_WIDE_W-1:0]    tod_wide,
    input  wire logic [`PTC_NARROW_W-1:0]  tod_narrow,
    // MAC transmit datapath
    output logic                           mac_valid,
    output logic                           mac_sop,
    output logic                           mac_eop,
    output ptc_pkg::ptc_data_t             mac_data,
    output logic [`PTC_ASYM_W-1:0]         corr_adjust
);
    import ptc_pkg::*;

    ptc_dev_t q_ff;
    ptc_dev_t nxt_q;

    // ----------------------------------------
    // Ones-complement helper
    // ----------------------------------------
    function automatic logic [`PTC_CSUM_W-1:0] csum_fix(
        input logic [`PTC_CSUM_W-1:0] old_sum,
        input logic [`PTC_CSUM_W-1:0] delta
    );
        logic [`PTC_CSUM_W:0] acc;
        acc = {1'b0, ~old_sum} + {1'b0, delta};
        acc = {1'b0, acc[`PTC_CSUM_W-1:0]} + {{`PTC_CSUM_W{1'b0}}, acc[`PTC_CSUM_W]};
        return ~acc[`PTC_CSUM_W-1:0];
    endfunction

    // ----------------------------------------
    // Next state
    // ----------------------------------------
    logic                      sop_in;
    logic                      cur_fix;
    logic                      cur_asym;
    logic [`PTC_BEAT_W-1:0]    cur_beat;
    logic [`PTC_BEAT_W-1:0]    cur_fbeat;
    logic [`PTC_LANE_W-1:0]    cur_lane;
    logic [`PTC_CSUM_W-1:0]    old_sum;
    logic [`PTC_CSUM_W-1:0]    new_sum;
    logic [`PTC_CSUM_W-1:0]    delta;
    ptc_data_t                 beat_data;

    always_comb begin
        nxt_q     = q_ff;
        sop_in    = lnk.tx_valid & lnk.tx_sop;
        old_sum   = '0;
        new_sum   = '0;
        delta     = '0;
        beat_data = lnk.tx_data;

        // Control for the current beat comes from the pins on SOP, else from the latch
        if (sop_in) begin
            // Two-step packets are never rewritten, so the fix is off for them
            cur_fix   = lnk.checksum_correct & one_step_mode
                        & ~lnk.two_step_request;
            cur_asym  = lnk.asymmetry_update;
            cur_beat  = '0;
            cur_fbeat = lnk.checksum_fix_offset[`PTC_OFS_W-1:`PTC_LANE_W];
            cur_lane  = lnk.checksum_fix_offset[`PTC_LANE_W-1:0];
        end else begin
            cur_fix   = q_ff.fix_en;
            cur_asym  = q_ff.asym_en;
            cur_beat  = q_ff.beat;
            cur_fbeat = q_ff.fix_beat;
            cur_lane  = q_ff.fix_lane;
        end

        // Checksum bytes are big-endian lanes L and L+1 of one beat
        if (cur_asym) begin
            delta = asymmetry_delay_value[`PTC_CSUM_W-1:0];
        end
        for (int k = 0; k < `PTC_BYTES - 1; k++) begin
            if (lnk.tx_valid && cur_fix && cur_beat == cur_fbeat
                    && cur_lane == k[`PTC_LANE_W-1:0]) begin
                old_sum = lnk.tx_data[`PTC_DATA_W-1-8*k -: `PTC_CSUM_W];
                new_sum = csum_fix(old_sum, delta);
                beat_data[`PTC_DATA_W-1-8*k -: `PTC_CSUM_W] = new_sum;
            end
        end

        // Output stage
        nxt_q.s_valid = lnk.tx_valid;
        nxt_q.s_sop   = sop_in;
        nxt_q.s_eop   = lnk.tx_valid & lnk.tx_eop;
        nxt_q.s_data  = lnk.tx_valid ? beat_data : '0;
        nxt_q.s_two   = sop_in & lnk.two_step_request;
        nxt_q.s_tag   = lnk.request_tag_in;

        if (lnk.tx_valid) begin
            nxt_q.beat = cur_beat + 1'b1;
            if (sop_in) begin
                nxt_q.fix_en   = cur_fix;
                nxt_q.asym_en  = cur_asym;
                nxt_q.fix_beat = cur_fbeat;
                nxt_q.fix_lane = cur_lane;
                nxt_q.corr_adj = cur_asym ? asymmetry_delay_value : '0;
            end
            if (lnk.tx_eop) begin
                nxt_q.fix_en  = 1'b0;
                nxt_q.asym_en = 1'b0;
            end
        end

        // Timestamps taken in the cycle the packet's first beat leaves
        nxt_q.wide_ok   = 1'b0;
        nxt_q.narrow_ok = 1'b0;
        if (q_ff.s_two) begin
            if (TOD_FMT == `PTC_FMT_WIDE || TOD_FMT == `PTC_FMT_BOTH) begin
                nxt_q.wide_ok  = 1'b1;
                nxt_q.wide_ts  = tod_wide;
                nxt_q.wide_tag = q_ff.s_tag;
            end
            if (TOD_FMT == `PTC_FMT_NARROW || TOD_FMT == `PTC_FMT_BOTH) begin
                nxt_q.narrow_ok  = 1'b1;
                nxt_q.narrow_ts  = tod_narrow;
                nxt_q.narrow_tag = q_ff.s_tag;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            q_ff <= '0;
        end else begin
            q_ff <= nxt_q;
        end
    end

    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    // The result trails mac_sop by one cycle so the time is taken at departure
    assign mac_valid                = q_ff.s_valid;
    assign mac_sop                  = q_ff.s_sop;
    assign mac_eop                  = q_ff.s_eop;
    assign mac_data                 = q_ff.s_data;
    assign corr_adjust              = q_ff.corr_adj;
    assign lnk.egress_ts_wide       = q_ff.wide_ts;
    assign lnk.egress_ts_wide_ok    = q_ff.wide_ok;
    assign lnk.egress_tag_wide      = q_ff.wide_tag;
    assign lnk.egress_ts_narrow     = q_ff.narrow_ts;
    assign lnk.egress_ts_narrow_ok  = q_ff.narrow_ok;
    assign lnk.egress_tag_narrow    = q_ff.narrow_tag;
endmodule

//--- design/ptc_cli.sv
`timescale 1ns/1ps
`include "ptc_cfg.svh"
module ptc_cli (
    // Clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic             pready,
    output logic [31:0]      prdata,
    output logic             pslverr,
    // Device side
    ptc_link_if.cli          lnk
);
    import ptc_pkg::*;

    ptc_cli_t q_ff;
    ptc_cli_t nxt_q;

    logic acc;
    logic wr;
    logic last;
    logic ofs_ok;
    logic start;

    always_comb begin
        nxt_q  = q_ff;
        acc    = psel & penable & ~q_ff.pready;
        wr     = acc & pwrite;
        last   = q_ff.cnt == q_ff.len - 1'b1;
        // Both checksum bytes must fit inside len beats
        ofs_ok = ({8'h00, q_ff.ofs} + 24'h000001) < ({16'h0000, q_ff.len} << 3);
        start  = 1'b0;

        // ----------------------------------------
        // APB slave
        // ----------------------------------------
        nxt_q.pready = acc;
        if (wr) begin
            case (paddr)
                `PTC_REG_CTRL: begin
                    nxt_q.ctrl = pwdata[`PTC_CTRL_W-1:0];
                    start      = pwdata[`PTC_CTRL_START] & (q_ff.st == PTC_IDLE);
                end
                `PTC_REG_OFS: nxt_q.ofs = pwdata[`PTC_OFS_W-1:0];
                `PTC_REG_LEN: nxt_q.len = pwdata[`PTC_LEN_W-1:0];
                `PTC_REG_TAG: nxt_q.tag = pwdata[`PTC_TAG_W-1:0];
                `PTC_REG_STAT: begin
                    if (pwdata[`PTC_STAT_WIDE]) nxt_q.got_wide = 1'b0;
                    if (pwdata[`PTC_STAT_NARROW]) nxt_q.got_narrow = 1'b0;
                end
                default: ;
            endcase
        end
        nxt_q.prdata = '0;
        if (acc && !pwrite) begin
            case (paddr)
                `PTC_REG_CTRL: nxt_q.prdata = 32'(q_ff.ctrl);
                `PTC_REG_OFS:  nxt_q.prdata = 32'(q_ff.ofs);
                `PTC_REG_LEN:  nxt_q.prdata = 32'(q_ff.len);
                `PTC_REG_TAG:  nxt_q.prdata = 32'(q_ff.tag);
                `PTC_REG_STAT: nxt_q.prdata = 32'({q_ff.got_narrow, q_ff.got_wide,
                                                   q_ff.st == PTC_SEND});
                `PTC_REG_RTAG: nxt_q.prdata = 32'(q_ff.rtag);
                `PTC_REG_TSLO: nxt_q.prdata = q_ff.ts[31:0];
                `PTC_REG_TSHI: nxt_q.prdata = q_ff.ts[63:32];
                default:       nxt_q.prdata = '0;
            endcase
        end

        // ----------------------------------------
        // Results: capture wins over a clear in the same cycle
        // ----------------------------------------
        if (lnk.egress_ts_narrow_ok) begin
            nxt_q.got_narrow = 1'b1;
            nxt_q.ts         = lnk.egress_ts_narrow;
            nxt_q.rtag       = lnk.egress_tag_narrow;
        end
        if (lnk.egress_ts_wide_ok) begin
            nxt_q.got_wide = 1'b1;
            nxt_q.rtag     = lnk.egress_tag_wide;
        end

        // ----------------------------------------
        // Packet sender
        // ----------------------------------------
        nxt_q.valid    = 1'b0;
        nxt_q.sop      = 1'b0;
        nxt_q.eop      = 1'b0;
        nxt_q.data     = '0;
        nxt_q.csum_req = 1'b0;
        nxt_q.csum_ofs = '0;
        nxt_q.asym_upd = 1'b0;
        nxt_q.two_req  = 1'b0;
        nxt_q.req_tag  = '0;
        nxt_q.ts_ins   = 1'b0;
        nxt_q.rt_upd   = 1'b0;
        case (q_ff.st)
            PTC_IDLE: begin
                if (start && pwdata[`PTC_LEN_W-1+8:8] == 8'h00 && q_ff.len != 8'h00) begin
                    nxt_q.st  = PTC_SEND;
                    nxt_q.cnt = '0;
                end
            end
            PTC_SEND: begin
                nxt_q.valid = 1'b1;
                nxt_q.data  = {`PTC_BYTES{q_ff.cnt}};
                nxt_q.eop   = last;
                nxt_q.cnt   = q_ff.cnt + 1'b1;
                if (q_ff.cnt == '0) begin
                    // Per-packet controls live only on the SOP beat
                    nxt_q.sop      = 1'b1;
                    nxt_q.csum_req = q_ff.ctrl[`PTC_CTRL_CSUM] & ofs_ok;
                    nxt_q.csum_ofs = q_ff.ofs;
                    nxt_q.asym_upd = q_ff.ctrl[`PTC_CTRL_ASYM];
                    nxt_q.two_req  = q_ff.ctrl[`PTC_CTRL_TWO];
                    nxt_q.req_tag  = q_ff.tag;
                    // Two-step excludes the one-step rewrites, and so does a checksum request,
                    // which keeps the checksum clear of any inserted field
                    nxt_q.ts_ins   = q_ff.ctrl[`PTC_CTRL_INS] &
                                     ~q_ff.ctrl[`PTC_CTRL_TWO] &
                                     ~q_ff.ctrl[`PTC_CTRL_CSUM];
                    nxt_q.rt_upd   = q_ff.ctrl[`PTC_CTRL_RT] &
                                     ~q_ff.ctrl[`PTC_CTRL_TWO] &
                                     ~q_ff.ctrl[`PTC_CTRL_CSUM];
                end
                if (last) begin
                    nxt_q.st = PTC_IDLE;
                end
            end
            default: nxt_q.st = PTC_IDLE;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            q_ff <= '0;
        end else begin
            q_ff <= nxt_q;
        end
    end

    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    assign pready                  = q_ff.pready;
    assign prdata                  = q_ff.prdata;
    assign pslverr                 = 1'b0;
    assign lnk.tx_valid            = q_ff.valid;
    assign lnk.tx_sop              = q_ff.sop;
    assign lnk.tx_eop              = q_ff.eop;
    assign lnk.tx_data             = q_ff.data;
    assign lnk.checksum_correct    = q_ff.csum_req;
    assign lnk.checksum_fix_offset = q_ff.csum_ofs;
    assign lnk.asymmetry_update    = q_ff.asym_upd;
    assign lnk.two_step_request    = q_ff.two_req;
    assign lnk.request_tag_in      = q_ff.req_tag;
    assign lnk.ts_insert           = q_ff.ts_ins;
    assign lnk.residence_update    = q_ff.rt_upd;
endmodule

//--- testbench/ptc_link_props.sv
`timescale 1ns/1ps
`include "ptc_cfg.svh"
module ptc_link_props
    import ptc_pkg::*;
(
    // Clock and reset
    input wire logic                     pclk,
    input wire logic                     presetn,
    // Request side
    input wire logic                     tx_sop,
    input wire logic                     two_step_request,
    input wire ptc_pkg::ptc_tag_t        request_tag_in,
    // Egress results
    input wire logic [`PTC_WIDE_W-1:0]   egress_ts_wide,
    input wire logic                     egress_ts_wide_ok,
    input wire ptc_pkg::ptc_tag_t        egress_tag_wide,
    input wire logic [`PTC_NARROW_W-1:0] egress_ts_narrow,
    input wire logic                     egress_ts_narrow_ok,
    input wire ptc_pkg::ptc_tag_t        egress_tag_narrow
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence two_step_sop;
        tx_sop && two_step_request;
    endsequence

    chk_wide_after_req: assert property (two_step_sop |-> ##2 egress_ts_wide_ok)
        else $error("wide result missing two cycles after request");
    chk_narrow_after_req: assert property (two_step_sop |-> ##2 egress_ts_narrow_ok)
        else $error("narrow result missing two cycles after request");
    chk_wide_tag_match: assert property (
        two_step_sop |-> ##2 egress_tag_wide == $past(request_tag_in, 2))
        else $error("wide tag differs from request tag");
    chk_narrow_tag_match: assert property (
        two_step_sop |-> ##2 egress_tag_narrow == $past(request_tag_in, 2))
        else $error("narrow tag differs from request tag");
    chk_wide_one_pulse: assert property (egress_ts_wide_ok |=> !egress_ts_wide_ok)
        else $error("wide valid longer than one cycle");
    chk_narrow_one_pulse: assert property (egress_ts_narrow_ok |=> !egress_ts_narrow_ok)
        else $error("narrow valid longer than one cycle");
    chk_narrow_has_cause: assert property (
        egress_ts_narrow_ok |-> $past(two_step_request, 2) && $past(tx_sop, 2))
        else $error("narrow valid without two-step request");
    chk_wide_ts_hold: assert property (!egress_ts_wide_ok |-> $stable(egress_ts_wide))
        else $error("wide timestamp moved without valid");
    chk_narrow_ts_hold: assert property (!egress_ts_narrow_ok |-> $stable(egress_ts_narrow))
        else $error("narrow timestamp moved without valid");
    chk_wide_tag_hold: assert property (!egress_ts_wide_ok |-> $stable(egress_tag_wide))
        else $error("wide tag moved without valid");
endmodule

//--- testbench/ptc_tx_timestamp_client_if_test.sv
`timescale 1ns/1ps
`include "ptc_cfg.svh"
module ptc_tx_timestamp_client_if_test;
    import ptc_pkg::*;
    localparam logic [31:0] ASYM = 32'h0001_2345;
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic        pready;
    logic [31:0] prdata;
    logic        one_step_mode = 1'b0;
    logic [95:0] tod_wide = 96'h1000;
    logic [63:0] tod_narrow = 64'h2000;
    logic [95:0] exp_wide;
    logic [63:0] exp_narrow;
    logic        mac_sop;
    ptc_data_t   mac_data, sop_tx, sop_mac;
    logic [31:0] corr_adjust;
    logic [2:0]  sop_ctl;
    int          n_ok = 0;
    int          n_fail = 0;
    int          samples_checked = 0;

    always #4 pclk = ~pclk;

    ptc_link_if lnk ();
    ptc_cli u_ptc_cli (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
        .pslverr(), .lnk(lnk.cli));
    ptc_dev u_ptc_dev (.pclk(pclk), .presetn(presetn), .lnk(lnk.dev),
        .one_step_mode(one_step_mode), .asymmetry_delay_value(ASYM), .tod_wide(tod_wide),
        .tod_narrow(tod_narrow), .mac_valid(), .mac_sop(mac_sop), .mac_eop(),
        .mac_data(mac_data), .corr_adjust(corr_adjust));
    ptc_link_props u_ptc_link_props (.pclk(pclk), .presetn(presetn), .tx_sop(lnk.tx_sop),
        .two_step_request(lnk.two_step_request), .request_tag_in(lnk.request_tag_in),
        .egress_ts_wide(lnk.egress_ts_wide), .egress_ts_wide_ok(lnk.egress_ts_wide_ok),
        .egress_tag_wide(lnk.egress_tag_wide), .egress_ts_narrow(lnk.egress_ts_narrow),
        .egress_ts_narrow_ok(lnk.egress_ts_narrow_ok), .egress_tag_narrow(lnk.egress_tag_narrow));

    // ----------------------------------------
    // Monitor: time of day runs every cycle so a late stamp shows
    // ----------------------------------------
    always @(posedge pclk) begin
        tod_narrow <= tod_narrow + 64'h1;
        tod_wide <= tod_wide + 96'h3;
        if (lnk.tx_sop === 1'b1) begin
            sop_tx <= lnk.tx_data;
            sop_ctl <= {lnk.checksum_correct, lnk.ts_insert, lnk.residence_update};
        end
        if (mac_sop === 1'b1) begin
            sop_mac <= mac_data;
            exp_narrow <= tod_narrow;
            exp_wide <= tod_wide;
        end
        if (lnk.egress_ts_narrow_ok === 1'b1) n_ok <= n_ok + 1;
    end

    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    task automatic check(input logic [127:0] seen, input logic [127:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_fail++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd,
                       output logic [31:0] rd);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic run_pkt(input logic [5:0] ctrl);
        logic [31:0] d;
        apb(1'b1, `PTC_REG_LEN, 32'h2, d);
        apb(1'b1, `PTC_REG_CTRL, {26'h0, ctrl} | 32'h1, d);
        for (int i = 0; i < 40; i++) begin
            apb(1'b0, `PTC_REG_STAT, 32'h0, d);
            if (d[0] === 1'b0) break;
        end
        // Results trail the last link beat by one cycle
        repeat (4) @(posedge pclk);
    endtask

    function automatic logic [15:0] fix(input logic [15:0] old, input logic [15:0] a);
        logic [16:0] s;
        s = {1'b0, ~old} + {1'b0, a};
        return ~(s[15:0] + {15'h0, s[16]});
    endfunction

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_two_step();
        logic [31:0] d;
        int n0;
        // Pass 1 also asks for one-step rewrites, which two-step must refuse
        for (int k = 0; k < 2; k++) begin
            one_step_mode <= (k == 1);
            apb(1'b1, `PTC_REG_TAG, k ? 32'ha5 : 32'h5a, d);
            apb(1'b1, `PTC_REG_STAT, 32'h6, d);
            apb(1'b0, `PTC_REG_STAT, 32'h0, d);
            check(d[2:1], 2'h0);
            n0 = n_ok;
            run_pkt(k ? 6'h3e : 6'h08);
            check(n_ok - n0, 1);
            check(sop_ctl, k ? 3'h4 : 3'h0);
            check(lnk.egress_ts_narrow, exp_narrow);
            check(lnk.egress_ts_wide, exp_wide);
            check(lnk.egress_tag_narrow, k ? 8'ha5 : 8'h5a);
            check(lnk.egress_tag_wide, k ? 8'ha5 : 8'h5a);
            check(sop_mac, sop_tx);
            apb(1'b0, `PTC_REG_STAT, 32'h0, d);
            check(d[2:1], 2'h3);
            apb(1'b0, `PTC_REG_RTAG, 32'h0, d);
            check(d, k ? 32'ha5 : 32'h5a);
        end
        apb(1'b0, 8'h20, 32'h0, d);
        check(d, 32'h0);
        $display("two-step test done");
    endtask

    task automatic t_fix();
        logic [31:0] d;
        ptc_data_t e;
        int n0;
        // Case 0 fixes with delay, 1 has no delay, 2 is outside one-step mode
        // Case 3 puts the checksum past the end and asks for rewrites beside it
        for (int k = 0; k < 4; k++) begin
            one_step_mode <= (k != 2);
            apb(1'b1, `PTC_REG_OFS, k == 3 ? 32'hf : 32'h0, d);
            n0 = n_ok;
            run_pkt(k == 3 ? 6'h36 : (k == 1 ? 6'h02 : 6'h06));
            e = sop_tx;
            if (k == 0) e[63:48] = fix(sop_tx[63:48], ASYM[15:0]);
            check(sop_mac, e);
            check(corr_adjust, k == 1 ? 32'h0 : ASYM);
            check(n_ok - n0, 0);
            check(sop_ctl, k == 3 ? 3'h0 : 3'h4);
        end
        $display("checksum test done");
    endtask

    task automatic give_verdict();
        $display("checked %0d, failed %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    initial begin
        #200000;
        n_fail++;
        give_verdict();
    end

    initial begin
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        t_two_step();
        t_fix();
        give_verdict();
    end
endmodule
